// >>> dcs_map.vh
`ifndef DCS_MAP_VH
`define DCS_MAP_VH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define DCS_IDX_CAL_SET_A      12'h050
`define DCS_IDX_CAL_SET_B      12'h051
`define DCS_IDX_CAL_CTL_A      12'h061
`define DCS_IDX_CAL_CTL_B      12'h081
`define DCS_IDX_SYNC_REF_CTL   12'h084
`define DCS_IDX_CLK_OUT_DIV    12'h094
`define DCS_IDX_DLY_LINE_PWR   12'h0C0
`define DCS_IDX_DLL_SEARCH     12'h0C1
`define DCS_IDX_DLL_LOCK_STAT  12'h0C3
`define DCS_IDX_DLL_RD_EN      12'h0C7
`define DCS_IDX_DLL_UPDATE     12'h0DB
`define DCS_IDX_DP_CLK_PWR     12'h100
`define DCS_IDX_LINK_MODE      12'h110
`define DCS_IDX_INTERP_MODE    12'h111
`define DCS_IDX_SYNC_OUT_ERR   12'h312
`define DCS_IDX_OSC_RESET      12'h792
`define DCS_IDX_MULT_LOCK_STAT 12'h7B5
// ----------------------------------------
// field positions
// ----------------------------------------
`define DCS_DIV_HALF_BIT       0
`define DCS_DIV_THIRD_BIT      1
`define DCS_LINK_DUAL_BIT      5
`define DCS_LINK_BAD_BIT       7
`define DCS_SREF_COUPLE_BIT    6
`define DCS_SREF_PD_BIT        0
`define DCS_OSC_RESET_BIT      1
`define DCS_DLL_UPD_BIT        0
`define DCS_DLL_SEARCH_EN_BIT  0
`define DCS_RD_EN_BIT          0
// ----------------------------------------
// reset values
// ----------------------------------------
`define DCS_RST_ZERO           8'h00
`define DCS_RST_PWR_DOWN       8'hFF
// ----------------------------------------
// timing figures (pclk in MHz, lock times in us)
// ----------------------------------------
`define DCS_PCLK_MHZ           100
`define DCS_MULT_LOCK_US       50
`define DCS_DLL_LOCK_US        10
`endif

// >>> dcs_lock_timer.v
`timescale 1ns/1ps
module dcs_lock_timer #(
    parameter CNT_W  = 24,
    parameter CYCLES = 5000
) (
    input  wire pclk,
    input  wire presetn,
    input  wire restart,
    input  wire run,
    output reg  locked_q
);
    reg [CNT_W-1:0] cnt_q;
    localparam integer     LAST_I = CYCLES - 1;
    localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];
    // lock only after an uninterrupted run following the last restart
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q    <= {CNT_W{1'b0}};
            locked_q <= 1'b0;
        end else if (restart || !run) begin
            cnt_q    <= {CNT_W{1'b0}};
            locked_q <= 1'b0;
        end else if (cnt_q == LAST) begin
            locked_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// >>> dcs_mode_check.v
`timescale 1ns/1ps
module dcs_mode_check (
    input  wire [5:0] serial_lane_mode,
    input  wire [3:0] main_path_upsample_mode,
    input  wire [3:0] channel_upsample_mode,
    output reg        combo_bad
);
    // simplified legality: main 1,2,4,6,8,12; channel 1,2,3,4,6,8
    reg main_ok;
    reg chan_ok;
    always @* begin
        main_ok = 1'b0;
        chan_ok = 1'b0;
        case (main_path_upsample_mode)
            4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hC: main_ok = 1'b1;
            default: main_ok = 1'b0;
        endcase
        case (channel_upsample_mode)
            4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8: chan_ok = 1'b1;
            default: chan_ok = 1'b0;
        endcase
        // dual link cannot bypass main path with channel interpolation
        combo_bad = !main_ok || !chan_ok ||
                    (serial_lane_mode[5] && main_path_upsample_mode == 4'h1
                     && channel_upsample_mode != 4'h1);
    end
endmodule

// >>> dcs_top.v
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "dcs_map.vh"
//
// Contract
// - third-divide bit gives oscillator over three
// - bit0 selects undivided or half oscillator
// - multiplier lock status bit0 reads locked
// - dll status bit0 reads loop locked; the code reads 0 there unless the read enable bit0 is set
// - link mode bit5 single or dual
// - interpolation nibbles main and channel
// - link mode bit7 flags invalid combination
// - sync ref bit6 selects ac or dc
module dcs_top #(
    parameter MULT_LOCK_CYCLES = `DCS_MULT_LOCK_US * `DCS_PCLK_MHZ,
    parameter DLL_LOCK_CYCLES  = `DCS_DLL_LOCK_US * `DCS_PCLK_MHZ
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [13:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [1:0]  conv_clk_div_sel,
    output reg         osc_reset_active,
    output reg         dll_update_pulse,
    output reg         dp_clk_enable,
    output reg         link_dual,
    output reg  [4:0]  serial_lane_mode,
    output reg  [3:0]  main_path_upsample_mode,
    output reg  [3:0]  channel_upsample_mode,
    output reg         sync_ref_coupling_select,
    output reg         sync_ref_receiver_powerdown,
    output reg  [3:0]  link_sync_request_duration
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    reg [7:0] cal_set_a_q;
    reg [7:0] cal_set_b_q;
    reg [7:0] cal_ctl_a_q;
    reg [7:0] cal_ctl_b_q;
    reg [7:0] sref_ctl_q;
    reg [7:0] clk_div_q;
    reg [7:0] dly_pwr_q;
    reg [7:0] dll_search_q;
    reg [7:0] dll_rd_en_q;
    reg [7:0] dll_upd_q;
    reg [7:0] dp_pwr_q;
    reg [5:0] link_mode_q;
    reg [7:0] interp_q;
    reg [7:0] sync_err_q;
    reg [7:0] osc_rst_q;
    reg       combo_bad_q;
    reg [7:0] rd_d;
    reg       hit_d;
    wire      combo_bad;
    wire      mult_locked;
    wire      dll_locked;
    wire [11:0] idx = paddr[13:2];
    wire      wr_en = psel && penable && pwrite && pready;
    wire      osc_in_reset = osc_rst_q[`DCS_OSC_RESET_BIT];
    wire      dll_pulse = dll_upd_q[`DCS_DLL_UPD_BIT];
    // ----------------------------------------
    // lock models
    // ----------------------------------------
    // multiplier relocks after each oscillator reset release
    dcs_lock_timer #(
        .CNT_W  (24),
        .CYCLES (MULT_LOCK_CYCLES)
    ) u_mult_lock (
        .pclk     (pclk),
        .presetn  (presetn),
        .restart  (osc_in_reset),
        .run      (1'b1),
        .locked_q (mult_locked)
    );
    // loop searches only when powered, enabled and multiplier locked; an update restarts it
    dcs_lock_timer #(
        .CNT_W  (24),
        .CYCLES (DLL_LOCK_CYCLES)
    ) u_dll_lock (
        .pclk     (pclk),
        .presetn  (presetn),
        .restart  (dll_pulse),
        .run      (dly_pwr_q == 8'h00 && mult_locked &&
                   dll_search_q[`DCS_DLL_SEARCH_EN_BIT]),
        .locked_q (dll_locked)
    );
    dcs_mode_check u_mode_check (
        .serial_lane_mode        (link_mode_q),
        .main_path_upsample_mode (interp_q[7:4]),
        .channel_upsample_mode   (interp_q[3:0]),
        .combo_bad               (combo_bad)
    );
    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_set_a_q  <= `DCS_RST_ZERO;
            cal_set_b_q  <= `DCS_RST_ZERO;
            cal_ctl_a_q  <= `DCS_RST_ZERO;
            cal_ctl_b_q  <= `DCS_RST_ZERO;
            sref_ctl_q   <= `DCS_RST_ZERO;
            clk_div_q    <= `DCS_RST_ZERO;
            dly_pwr_q    <= `DCS_RST_PWR_DOWN;
            dll_search_q <= `DCS_RST_ZERO;
            dll_rd_en_q  <= `DCS_RST_ZERO;
            dll_upd_q    <= `DCS_RST_ZERO;
            dp_pwr_q     <= `DCS_RST_PWR_DOWN;
            link_mode_q  <= 6'h00;
            interp_q     <= 8'h11;
            sync_err_q   <= `DCS_RST_ZERO;
            osc_rst_q    <= `DCS_RST_ZERO;
            combo_bad_q  <= 1'b0;
        end else begin
            combo_bad_q <= combo_bad;
            if (wr_en) begin
                case (idx)
                    `DCS_IDX_CAL_SET_A:    cal_set_a_q  <= pwdata[7:0];
                    `DCS_IDX_CAL_SET_B:    cal_set_b_q  <= pwdata[7:0];
                    `DCS_IDX_CAL_CTL_A:    cal_ctl_a_q  <= pwdata[7:0];
                    `DCS_IDX_CAL_CTL_B:    cal_ctl_b_q  <= pwdata[7:0];
                    `DCS_IDX_SYNC_REF_CTL: sref_ctl_q   <= pwdata[7:0];
                    `DCS_IDX_CLK_OUT_DIV:  clk_div_q    <= pwdata[7:0];
                    `DCS_IDX_DLY_LINE_PWR: dly_pwr_q    <= pwdata[7:0];
                    `DCS_IDX_DLL_SEARCH:   dll_search_q <= pwdata[7:0];
                    `DCS_IDX_DLL_RD_EN:    dll_rd_en_q  <= pwdata[7:0];
                    `DCS_IDX_DLL_UPDATE:   dll_upd_q    <= pwdata[7:0];
                    `DCS_IDX_DP_CLK_PWR:   dp_pwr_q     <= pwdata[7:0];
                    `DCS_IDX_LINK_MODE:    link_mode_q  <= pwdata[5:0];
                    `DCS_IDX_INTERP_MODE:  interp_q     <= pwdata[7:0];
                    `DCS_IDX_SYNC_OUT_ERR: sync_err_q   <= pwdata[7:0];
                    `DCS_IDX_OSC_RESET:    osc_rst_q    <= pwdata[7:0];
                    default: ;
                endcase
            end
        end
    end
    // ----------------------------------------
    // read mux and apb answer
    // ----------------------------------------
    always @* begin
        rd_d  = 8'h00;
        hit_d = 1'b1;
        case (idx)
            `DCS_IDX_CAL_SET_A:    rd_d = cal_set_a_q;
            `DCS_IDX_CAL_SET_B:    rd_d = cal_set_b_q;
            `DCS_IDX_CAL_CTL_A:    rd_d = cal_ctl_a_q;
            `DCS_IDX_CAL_CTL_B:    rd_d = cal_ctl_b_q;
            `DCS_IDX_SYNC_REF_CTL: rd_d = sref_ctl_q;
            `DCS_IDX_CLK_OUT_DIV:  rd_d = clk_div_q;
            `DCS_IDX_DLY_LINE_PWR: rd_d = dly_pwr_q;
            `DCS_IDX_DLL_SEARCH:   rd_d = dll_search_q;
            // status hidden until the read enable is set
            `DCS_IDX_DLL_LOCK_STAT:
                rd_d = {7'h00, dll_locked &
                        dll_rd_en_q[`DCS_RD_EN_BIT]};
            `DCS_IDX_DLL_RD_EN:    rd_d = dll_rd_en_q;
            `DCS_IDX_DLL_UPDATE:   rd_d = dll_upd_q;
            `DCS_IDX_DP_CLK_PWR:   rd_d = dp_pwr_q;
            `DCS_IDX_LINK_MODE:
                rd_d = {combo_bad_q, 1'b0, link_mode_q};
            `DCS_IDX_INTERP_MODE:  rd_d = interp_q;
            `DCS_IDX_SYNC_OUT_ERR: rd_d = sync_err_q;
            `DCS_IDX_OSC_RESET:    rd_d = osc_rst_q;
            `DCS_IDX_MULT_LOCK_STAT:
                rd_d = {7'h00, mult_locked};
            default: hit_d = 1'b0;
        endcase
    end
    // no wait state: pready rises in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !hit_d;
            prdata  <= (pwrite || !hit_d) ? 32'h0000_0000 : {24'h000000, rd_d};
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end
    // ----------------------------------------
    // control outputs
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_clk_div_sel            <= 2'b00;
            osc_reset_active            <= 1'b0;
            dll_update_pulse            <= 1'b0;
            dp_clk_enable               <= 1'b0;
            link_dual                   <= 1'b0;
            serial_lane_mode            <= 5'h00;
            main_path_upsample_mode     <= 4'h1;
            channel_upsample_mode       <= 4'h1;
            sync_ref_coupling_select    <= 1'b0;
            sync_ref_receiver_powerdown <= 1'b0;
            link_sync_request_duration  <= 4'h0;
        end else begin
            // 00 undivided, 01 half, 10 third; both set is illegal, third wins
            if (clk_div_q[`DCS_DIV_THIRD_BIT])
                conv_clk_div_sel <= 2'b10;
            else if (clk_div_q[`DCS_DIV_HALF_BIT])
                conv_clk_div_sel <= 2'b01;
            else
                conv_clk_div_sel <= 2'b00;
            osc_reset_active <= osc_in_reset;
            dll_update_pulse <= dll_pulse;
            dp_clk_enable    <= (dp_pwr_q == 8'h00);
            link_dual        <= link_mode_q[`DCS_LINK_DUAL_BIT];
            serial_lane_mode <= link_mode_q[4:0];
            main_path_upsample_mode <= interp_q[7:4];
            channel_upsample_mode   <= interp_q[3:0];
            sync_ref_coupling_select <=
                sref_ctl_q[`DCS_SREF_COUPLE_BIT];
            sync_ref_receiver_powerdown <= sref_ctl_q[`DCS_SREF_PD_BIT];
            link_sync_request_duration  <= sync_err_q[7:4];
        end
    end
endmodule

// >>> dcs_top_chk.sv
`timescale 1ns/1ps
`include "dcs_map.vh"
module dcs_top_chk #(
    parameter MULT_LOCK_CYCLES = 20,
    parameter DLL_LOCK_CYCLES  = 10
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [1:0]  conv_clk_div_sel,
    input wire        osc_reset_active,
    input wire        dp_clk_enable,
    input wire        link_dual,
    input wire [4:0]  serial_lane_mode,
    input wire [3:0]  main_path_upsample_mode,
    input wire [3:0]  channel_upsample_mode,
    input wire        sync_ref_coupling_select
);
    wire [11:0] idx = paddr[13:2];
    wire        wr  = psel && penable && pready && pwrite;
    wire        rd  = psel && penable && pready && !pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    AST_READY: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready is not a one-cycle answer");
    AST_REFUSE: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    // ----------------------------------------
    // register effects, outputs lag one cycle
    // ----------------------------------------
    AST_THIRD: assert property (wr && idx == `DCS_IDX_CLK_OUT_DIV
        && pwdata[1:0] == 2'b10 |-> ##2 conv_clk_div_sel == 2'b10)
        else $error("third divide not selected");
    AST_HALF: assert property (wr && idx == `DCS_IDX_CLK_OUT_DIV
        && !pwdata[1] |-> ##2 conv_clk_div_sel == {1'b0, $past(pwdata[0], 2)})
        else $error("half divide select wrong");
    AST_MLOCK: assert property (
        rd && idx == `DCS_IDX_MULT_LOCK_STAT && osc_reset_active
        && $past(osc_reset_active) |-> prdata[0] == 1'b0)
        else $error("lock read high during oscillator reset");
    AST_DPCLK: assert property (wr && idx == `DCS_IDX_DP_CLK_PWR
        && pwdata[7:0] == 8'h00 |-> ##2 dp_clk_enable)
        else $error("datapath clocks not enabled");
    AST_LINK: assert property (
        wr && idx == `DCS_IDX_LINK_MODE |-> ##2
        {link_dual, serial_lane_mode} == $past(pwdata[5:0], 2))
        else $error("link mode outputs wrong");
    AST_INTERP: assert property (
        wr && idx == `DCS_IDX_INTERP_MODE |-> ##2
        {main_path_upsample_mode, channel_upsample_mode}
        == $past(pwdata[7:0], 2))
        else $error("upsample mode outputs wrong");
    AST_SREF: assert property (
        wr && idx == `DCS_IDX_SYNC_REF_CTL |-> ##2
        sync_ref_coupling_select == $past(pwdata[6], 2))
        else $error("coupling select wrong");
endmodule
bind dcs_top dcs_top_chk #(
    .MULT_LOCK_CYCLES(MULT_LOCK_CYCLES), .DLL_LOCK_CYCLES(DLL_LOCK_CYCLES)
) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_clk_div_sel(conv_clk_div_sel),
    .osc_reset_active(osc_reset_active), .dp_clk_enable(dp_clk_enable),
    .link_dual(link_dual), .serial_lane_mode(serial_lane_mode),
    .main_path_upsample_mode(main_path_upsample_mode),
    .channel_upsample_mode(channel_upsample_mode),
    .sync_ref_coupling_select(sync_ref_coupling_select)
);

// >>> test_dac_clock_startup_config.sv
`timescale 1ns/1ps
`include "dcs_map.vh"
module test_dac_clock_startup_config;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [13:0] paddr   = 14'h0000;
    logic [31:0] pwdata  = 32'h0000_0000;
    wire  [31:0] prdata;
    wire         pready, pslverr, osc_rst, upd, dp_en, dual, cpl, pd;
    wire  [1:0]  div_sel;
    wire  [4:0]  lane;
    wire  [3:0]  main_m, chan_m, dur;
    logic [31:0] rdata;
    logic        serr;
    int          fail_count = 0;
    int          cmp_count  = 0;
    logic [11:0] cal_i [5] = '{12'h050, 12'h061, 12'h051, 12'h051, 12'h081};
    logic [7:0]  cal_d [5] = '{8'h2A, 8'h68, 8'h82, 8'h83, 8'h03};

    // short lock counts keep the run brief
    dcs_top #(.MULT_LOCK_CYCLES(20), .DLL_LOCK_CYCLES(10)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_clk_div_sel(div_sel),
        .osc_reset_active(osc_rst), .dll_update_pulse(upd),
        .dp_clk_enable(dp_en), .link_dual(dual), .serial_lane_mode(lane),
        .main_path_upsample_mode(main_m), .channel_upsample_mode(chan_m),
        .sync_ref_coupling_select(cpl), .sync_ref_receiver_powerdown(pd),
        .link_sync_request_duration(dur)
    );

    initial forever #5 pclk = ~pclk;

    task automatic end_of_test();
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ----------------------------------------
    // apb master: hold request until pready
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] i,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready_wait", 32'h1, 32'(n));
    endtask

    // two edges let the lagging outputs settle
    task automatic wr(input logic [11:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
        repeat (2) @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk($sformatf("reg_%h", i), {24'h00_0000, e}, rdata);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(`DCS_IDX_INTERP_MODE, 8'h11);
        rd(`DCS_IDX_DP_CLK_PWR, 8'hFF);
        chk("dp_en", 32'h0, 32'(dp_en));
        for (int k = 0; k < 3; k++) begin
            wr(`DCS_IDX_CLK_OUT_DIV, k[7:0]);
            chk("div_sel", k, 32'(div_sel));
            rd(`DCS_IDX_CLK_OUT_DIV, k[7:0]);
        end
        wr(`DCS_IDX_OSC_RESET, 8'h02);
        chk("osc_rst", 32'h1, 32'(osc_rst));
        rd(`DCS_IDX_MULT_LOCK_STAT, 8'h00);
        wr(`DCS_IDX_OSC_RESET, 8'h00);
        rd(`DCS_IDX_MULT_LOCK_STAT, 8'h00);
        repeat (30) @(posedge pclk);
        wr(`DCS_IDX_MULT_LOCK_STAT, 8'h00);
        rd(`DCS_IDX_MULT_LOCK_STAT, 8'h01);
        wait (rdata[0] === 1'b1);
        wr(`DCS_IDX_DLY_LINE_PWR, 8'h00);
        wr(`DCS_IDX_DLL_UPDATE, 8'h00);
        wr(`DCS_IDX_DLL_UPDATE, 8'h01);
        chk("upd", 32'h1, 32'(upd));
        wr(`DCS_IDX_DLL_UPDATE, 8'h00);
        wr(`DCS_IDX_DLL_SEARCH, 8'h48);
        wr(`DCS_IDX_DLL_SEARCH, 8'h49);
        repeat (20) @(posedge pclk);
        rd(`DCS_IDX_DLL_LOCK_STAT, 8'h00);
        wr(`DCS_IDX_DLL_RD_EN, 8'h01);
        rd(`DCS_IDX_DLL_LOCK_STAT, 8'h01);
        wait (rdata[0] === 1'b1);
        for (int k = 0; k < 5; k++) begin
            wr(cal_i[k], cal_d[k]);
            rd(cal_i[k], cal_d[k]);
        end
        wr(`DCS_IDX_DP_CLK_PWR, 8'h00);
        chk("dp_en", 32'h1, 32'(dp_en));
        wr(`DCS_IDX_LINK_MODE, 8'hE5);
        chk("link", 32'h25, 32'({dual, lane}));
        rd(`DCS_IDX_LINK_MODE, 8'h25);
        wr(`DCS_IDX_INTERP_MODE, 8'h12);
        chk("interp", 32'h12, 32'({main_m, chan_m}));
        rd(`DCS_IDX_LINK_MODE, 8'hA5);
        wr(`DCS_IDX_INTERP_MODE, 8'h82);
        rd(`DCS_IDX_LINK_MODE, 8'h25);
        wr(`DCS_IDX_SYNC_REF_CTL, 8'h41);
        chk("sref", 32'h3, 32'({cpl, pd}));
        wr(`DCS_IDX_SYNC_OUT_ERR, 8'h50);
        chk("dur", 32'h5, 32'(dur));
        apb(1'b0, 12'h200, 8'h00);
        chk("pslverr", 32'h1, 32'(serr));
        chk("prdata", 32'h0, rdata);
        end_of_test();
    end

    // guard against a hung handshake
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        end_of_test();
    end
endmodule
